// *** core/frab_alu.sv ***
`timescale 1ns/1ps
module frab_alu (
  // Operand and result bundle
  frab_alu_if.alu bus
);

  // Result value and write targets per operation
  always_comb
  begin
    bus.result = frab_pkg::DATA_ZERO;
    bus.wr_acc = 1'b0;
    bus.wr_file = 1'b0;
    bus.upd_zero = 1'b0;
    bus.branch = 1'b0;
    unique case (bus.op)
      frab_pkg::OP_NOP:
      begin
        bus.result = bus.acc;
      end
      frab_pkg::OP_INCREMENT_FILE:
      begin
        bus.result = 8'(bus.fdata + frab_pkg::DATA_ONE);
        bus.wr_acc = (bus.dest == frab_pkg::DEST_ACC);
        bus.wr_file = (bus.dest == frab_pkg::DEST_FILE);
        bus.upd_zero = 1'b1;
      end
      frab_pkg::OP_INCREMENT_SKIP_ZERO:
      begin
        // Flags left alone
        bus.result = 8'(bus.fdata + frab_pkg::DATA_ONE);
        bus.wr_acc = (bus.dest == frab_pkg::DEST_ACC);
        bus.wr_file = (bus.dest == frab_pkg::DEST_FILE);
      end
      frab_pkg::OP_UNCONDITIONAL_BRANCH:
      begin
        // Only the program counter moves
        bus.result = bus.acc;
        bus.branch = 1'b1;
      end
      frab_pkg::OP_OR_LITERAL_ACCUM:
      begin
        bus.result = bus.acc | bus.lit;
        bus.wr_acc = 1'b1;
        bus.upd_zero = 1'b1;
      end
      frab_pkg::OP_OR_ACCUM_FILE:
      begin
        bus.result = bus.acc | bus.fdata;
        bus.wr_acc = (bus.dest == frab_pkg::DEST_ACC);
        bus.wr_file = (bus.dest == frab_pkg::DEST_FILE);
        bus.upd_zero = 1'b1;
      end
      frab_pkg::OP_STORE_ACCUM_TO_FILE:
      begin
        bus.result = bus.acc;
        bus.wr_file = 1'b1;
      end
      frab_pkg::OP_MOVE_FILE:
      begin
        // In-place form rewrites the same value as a test
        bus.result = bus.fdata;
        bus.wr_acc = (bus.dest == frab_pkg::DEST_ACC);
        bus.wr_file = (bus.dest == frab_pkg::DEST_FILE);
        bus.upd_zero = 1'b1;
      end
    endcase
  end

  // Zero detect on the 8-bit result
  assign bus.zero = (bus.result == frab_pkg::DATA_ZERO);
  // Skip only for the skip form with a zero result
  assign bus.skip = (bus.op == frab_pkg::OP_INCREMENT_SKIP_ZERO) &&
                    bus.zero;

endmodule // frab_alu

// *** core/frab_alu_if.sv ***
`timescale 1ns/1ps
interface frab_alu_if;
  // Operands from the core
  frab_pkg::frab_op_t op;
  logic dest;
  logic [7:0] acc;
  logic [7:0] fdata;
  logic [7:0] lit;
  // Results back to the core
  logic [7:0] result;
  logic zero;
  logic wr_acc;
  logic wr_file;
  logic upd_zero;
  logic skip;
  logic branch;

  modport alu (
    input op, dest, acc, fdata, lit,
    output result, zero, wr_acc, wr_file, upd_zero, skip, branch
  );
  modport core (
    output op, dest, acc, fdata, lit,
    input result, zero, wr_acc, wr_file, upd_zero, skip, branch
  );
endinterface // frab_alu_if

// *** core/frab_core.sv ***
`timescale 1ns/1ps
module frab_core (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Decoded instruction
  input wire logic instr_valid_i,
  input wire frab_pkg::frab_op_t op_i,
  input wire logic [4:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [8:0] lit_i,
  // Page select bits of the status register
  input wire logic [1:0] page_sel_i,
  // File register observation port
  input wire logic [4:0] peek_addr_i,
  output logic [7:0] peek_data_o,
  // Architectural state
  output logic [7:0] accum_o,
  output logic zero_o,
  output logic [10:0] pc_o,
  output logic skip_pending_o,
  // File write notification
  output logic file_wr_o,
  output logic [4:0] file_wr_addr_o,
  output logic [7:0] file_wr_data_o
);

  frab_pkg::frab_state_t state; // Sequencer state
  frab_pkg::frab_state_t next_state; // Sequencer next state
  logic [7:0] file_q [frab_pkg::FILE_CNT]; // File register storage
  logic [7:0] rd_data; // Addressed file register
  logic exec; // Instruction executes this cycle
  logic discard; // Fetched instruction dropped this cycle

  frab_alu_if alu_bus ();

  // Operand read
  assign rd_data = file_q[file_addr_i];
  // Execute only in the normal state
  assign exec = ce_i && instr_valid_i && (state == frab_pkg::ST_EXEC);
  // Dropped instruction behaves as a no-operation
  assign discard = ce_i && instr_valid_i &&
                   (state == frab_pkg::ST_FLUSH);

  // Operands into the arithmetic unit
  assign alu_bus.op = op_i;
  assign alu_bus.dest = dest_i;
  assign alu_bus.acc = accum_o;
  assign alu_bus.fdata = rd_data;
  assign alu_bus.lit = lit_i[7:0];

  frab_alu u_alu (
    .bus(alu_bus.alu)
  );

  // Next state: flush after a branch or a taken skip
  always_comb
  begin
    next_state = state;
    unique case (state)
      frab_pkg::ST_EXEC:
      begin
        if (exec && (alu_bus.skip || alu_bus.branch))
        begin
          next_state = frab_pkg::ST_FLUSH;
        end
      end
      frab_pkg::ST_FLUSH:
      begin
        if (discard)
        begin
          next_state = frab_pkg::ST_EXEC;
        end
      end
      default:
      begin
        next_state = frab_pkg::ST_EXEC;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= frab_pkg::ST_EXEC;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // Pending flush shown outside
  assign skip_pending_o = state[1];

  // Program counter
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_o <= frab_pkg::PC_RST;
    end
    else if (exec && alu_bus.branch)
    begin
      // Page bits fill the top of the target
      pc_o <= {page_sel_i, lit_i};
    end
    else if (exec || discard)
    begin
      pc_o <= 11'(pc_o + frab_pkg::PC_STEP);
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      accum_o <= frab_pkg::ACC_RST;
    end
    else if (exec && alu_bus.wr_acc)
    begin
      accum_o <= alu_bus.result;
    end
  end

  // Zero flag, only for the flag-updating operations
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      zero_o <= frab_pkg::ZERO_RST;
    end
    else if (exec && alu_bus.upd_zero)
    begin
      zero_o <= alu_bus.zero;
    end
  end

  // File registers, one process per entry
  for (genvar gi = 0; gi < frab_pkg::FILE_CNT; gi++)
  begin : g_file
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        file_q[gi] <= frab_pkg::FILE_RST;
      end
      else if (exec && alu_bus.wr_file && (file_addr_i == 5'(gi)))
      begin
        file_q[gi] <= alu_bus.result;
      end
    end
  end

  // Write notification toward the file register space
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      file_wr_o <= 1'b0;
      file_wr_addr_o <= 5'h00;
      file_wr_data_o <= frab_pkg::FILE_RST;
    end
    else if (ce_i)
    begin
      file_wr_o <= exec && alu_bus.wr_file;
      if (exec && alu_bus.wr_file)
      begin
        file_wr_addr_o <= file_addr_i;
        file_wr_data_o <= alu_bus.result;
      end
    end
  end

  // Observation read
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peek_data_o <= frab_pkg::FILE_RST;
    end
    else if (ce_i)
    begin
      peek_data_o <= file_q[peek_addr_i];
    end
  end

  // Checks
  logic [7:0] chk_inc; // Expected increment
  logic [7:0] chk_lit; // Literal low byte
  assign chk_inc = 8'(rd_data + frab_pkg::DATA_ONE);
  assign chk_lit = lit_i[7:0];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_inc_acc;
    exec && op_i == frab_pkg::OP_INCREMENT_FILE && !dest_i |=>
      accum_o == $past(chk_inc) && zero_o == ($past(chk_inc) == 8'h00);
  endproperty
  a_inc_acc: assert property (p_inc_acc)
    else $error("increment to accumulator wrong");

  property p_inc_file;
    exec && op_i == frab_pkg::OP_INCREMENT_FILE && dest_i |=>
      file_wr_o && file_wr_data_o == $past(chk_inc) && $stable(accum_o);
  endproperty
  a_inc_file: assert property (p_inc_file)
    else $error("increment to file wrong");

  property p_skip_flags;
    exec && op_i == frab_pkg::OP_INCREMENT_SKIP_ZERO |=> $stable(zero_o);
  endproperty
  a_skip_flags: assert property (p_skip_flags)
    else $error("increment-skip changed zero flag");

  property p_skip_taken;
    exec && op_i == frab_pkg::OP_INCREMENT_SKIP_ZERO |=>
      skip_pending_o == ($past(chk_inc) == 8'h00);
  endproperty
  a_skip_taken: assert property (p_skip_taken)
    else $error("skip decision wrong");

  property p_discard_nop;
    skip_pending_o && ce_i && instr_valid_i |=>
      !skip_pending_o && !file_wr_o && $stable(accum_o) && $stable(zero_o);
  endproperty
  a_discard_nop: assert property (p_discard_nop)
    else $error("discarded instruction had an effect");

  property p_branch_pc;
    exec && op_i == frab_pkg::OP_UNCONDITIONAL_BRANCH |=>
      pc_o == {$past(page_sel_i), $past(lit_i)};
  endproperty
  a_branch_pc: assert property (p_branch_pc)
    else $error("branch target wrong");

  property p_branch_two;
    exec && op_i == frab_pkg::OP_UNCONDITIONAL_BRANCH |=>
      skip_pending_o && $stable(zero_o) && $stable(accum_o);
  endproperty
  a_branch_two: assert property (p_branch_two)
    else $error("branch not two cycles or flags touched");

  property p_or_lit;
    exec && op_i == frab_pkg::OP_OR_LITERAL_ACCUM |=>
      accum_o == ($past(accum_o) | $past(chk_lit));
  endproperty
  a_or_lit: assert property (p_or_lit)
    else $error("OR literal result wrong");

  property p_or_file;
    exec && op_i == frab_pkg::OP_OR_ACCUM_FILE && dest_i |=>
      file_wr_o && file_wr_data_o == ($past(accum_o) | $past(rd_data));
  endproperty
  a_or_file: assert property (p_or_file)
    else $error("OR with file result wrong");

  property p_store;
    exec && op_i == frab_pkg::OP_STORE_ACCUM_TO_FILE |=>
      file_wr_o && file_wr_data_o == $past(accum_o) && $stable(zero_o);
  endproperty
  a_store: assert property (p_store)
    else $error("store accumulator wrong");

  property p_move;
    exec && op_i == frab_pkg::OP_MOVE_FILE && !dest_i |=>
      accum_o == $past(rd_data) && zero_o == ($past(rd_data) == 8'h00);
  endproperty
  a_move: assert property (p_move)
    else $error("move file wrong");

  property p_zero;
    exec && alu_bus.upd_zero |=> zero_o == ($past(alu_bus.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  // Main scenarios
  c_skip: cover property (exec && alu_bus.skip ##1 discard);
  c_branch: cover property (exec && alu_bus.branch ##1 discard);
  c_move_test: cover property (exec && op_i == frab_pkg::OP_MOVE_FILE &&
                               dest_i && rd_data == 8'h00);

endmodule // frab_core

// *** core/frab_pkg.sv ***
package frab_pkg;

  // Datapath widths
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 11;
  localparam int LIT_W = 9;
  localparam int PAGE_W = 2;
  localparam int FILE_CNT = 32;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic ZERO_RST = 1'b0;

  // Constants used by the arithmetic
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [10:0] PC_STEP = 11'h001;

  // Destination select values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Operation codes handed over by the decoder
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_INCREMENT_FILE = 3'h1,
    OP_INCREMENT_SKIP_ZERO = 3'h2,
    OP_UNCONDITIONAL_BRANCH = 3'h3,
    OP_OR_LITERAL_ACCUM = 3'h4,
    OP_OR_ACCUM_FILE = 3'h5,
    OP_STORE_ACCUM_TO_FILE = 3'h6,
    OP_MOVE_FILE = 3'h7
  } frab_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } frab_state_t;

endpackage

// *** testbench/frab_dec_model.sv ***
`timescale 1ns/1ps
// Decoder side: hands the core one instruction per taken edge
module frab_dec_model (
  // Clock
  input wire logic clk_sys_i,
  // Decoded instruction
  output logic instr_valid_o,
  output frab_pkg::frab_op_t op_o,
  output logic [4:0] file_addr_o,
  output logic dest_o,
  output logic [8:0] lit_o
);
  // Idle at time zero
  initial
  begin
    instr_valid_o = 1'b0;
    op_o = frab_pkg::OP_NOP;
    file_addr_o = 5'h00;
    dest_o = 1'b0;
    lit_o = 9'h000;
  end

  // Present one instruction and hold it across one edge
  task automatic issue(input frab_pkg::frab_op_t o, input logic [4:0] a,
    input logic d, input logic [8:0] k);
    instr_valid_o = 1'b1;
    op_o = o;
    file_addr_o = a;
    dest_o = d;
    lit_o = k;
    @(posedge clk_sys_i);
    #1;
  endtask

  // Drop valid; stale fields are scrambled so nothing leans on them
  task automatic idle();
    instr_valid_o = 1'b0;
    op_o = frab_pkg::frab_op_t'(~op_o);
    file_addr_o = ~file_addr_o;
    dest_o = ~dest_o;
    lit_o = ~lit_o;
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule // frab_dec_model

// *** testbench/tb_file_reg_alu_branch_subset.sv ***
`timescale 1ns/1ps
module tb_file_reg_alu_branch_subset;
  // Clock, reset and free inputs
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [1:0] page_sel_i = 2'b00;
  logic [4:0] peek_addr_i = 5'h00;
  // Decoder to core
  logic instr_valid;
  frab_pkg::frab_op_t op;
  logic [4:0] file_addr;
  logic dest;
  logic [8:0] lit;
  // Observed state
  logic [7:0] peek_data_o;
  logic [7:0] accum_o;
  logic zero_o;
  logic [10:0] pc_o;
  logic skip_pending_o;
  logic file_wr_o;
  logic [4:0] file_wr_addr_o;
  logic [7:0] file_wr_data_o;
  // Bookkeeping
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [10:0] pc_e = 11'h000;

  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;

  frab_dec_model u_dec (
    .clk_sys_i(clk_sys_i), .instr_valid_o(instr_valid), .op_o(op),
    .file_addr_o(file_addr), .dest_o(dest), .lit_o(lit)
  );

  frab_core DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid), .op_i(op), .file_addr_i(file_addr),
    .dest_i(dest), .lit_i(lit), .page_sel_i(page_sel_i),
    .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o),
    .accum_o(accum_o), .zero_o(zero_o), .pc_o(pc_o),
    .skip_pending_o(skip_pending_o), .file_wr_o(file_wr_o),
    .file_wr_addr_o(file_wr_addr_o), .file_wr_data_o(file_wr_data_o)
  );

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [10:0] seen,
    input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // One accepted instruction advances the expected pc
  task automatic ex(input frab_pkg::frab_op_t o, input logic [4:0] a,
    input logic d, input logic [8:0] k);
    u_dec.issue(o, a, d, k);
    pc_e = pc_e + 11'h001;
  endtask

  // Architectural state after the last edge
  task automatic st(input logic [7:0] a, input logic z, input logic s);
    chk("accum", accum_o, a);
    chk("zero", zero_o, z);
    chk("skip", skip_pending_o, s);
    chk("pc", pc_o, pc_e);
  endtask

  // File write notification of the last edge
  task automatic wrc(input logic w, input logic [4:0] a,
    input logic [7:0] d);
    chk("file_wr", file_wr_o, w);
    if (w)
    begin
      chk("wr_addr", file_wr_addr_o, a);
      chk("wr_data", file_wr_data_o, d);
    end
  endtask

  // Read a file register through the observation port
  task automatic peek(input logic [4:0] a, input logic [7:0] d);
    peek_addr_i = a;
    u_dec.idle();
    chk("peek", peek_data_o, d);
  endtask

  // OR literal, bit 8 of the literal ignored
  task automatic t_or_lit();
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h000);
    st(8'h00, 1'b1, 1'b0);
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h010);
    st(8'h10, 1'b0, 1'b0);
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h101);
    st(8'h11, 1'b0, 1'b0);
  endtask

  // Move both ways, store keeps zero set
  task automatic t_move_store();
    ex(frab_pkg::OP_MOVE_FILE, 5'h1f, 1'b0, 9'h000);
    st(8'h00, 1'b1, 1'b0);
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h0ff);
    ex(frab_pkg::OP_MOVE_FILE, 5'h1f, 1'b1, 9'h000);
    st(8'hff, 1'b1, 1'b0);
    wrc(1'b1, 5'h1f, 8'h00);
    ex(frab_pkg::OP_STORE_ACCUM_TO_FILE, 5'h03, 1'b0, 9'h000);
    st(8'hff, 1'b1, 1'b0);
    wrc(1'b1, 5'h03, 8'hff);
    peek(5'h03, 8'hff);
  endtask

  // Increment with wrap to zero, both destinations
  task automatic t_increment_file();
    ex(frab_pkg::OP_INCREMENT_FILE, 5'h03, 1'b0, 9'h000);
    st(8'h00, 1'b1, 1'b0);
    wrc(1'b0, 5'h00, 8'h00);
    peek(5'h03, 8'hff);
    ex(frab_pkg::OP_INCREMENT_FILE, 5'h03, 1'b1, 9'h000);
    wrc(1'b1, 5'h03, 8'h00);
    ex(frab_pkg::OP_INCREMENT_FILE, 5'h03, 1'b1, 9'h000);
    st(8'h00, 1'b0, 1'b0);
    wrc(1'b1, 5'h03, 8'h01);
  endtask

  // OR accumulator with file into either destination
  task automatic t_orwf();
    ex(frab_pkg::OP_OR_ACCUM_FILE, 5'h03, 1'b0, 9'h000);
    st(8'h01, 1'b0, 1'b0);
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h080);
    ex(frab_pkg::OP_OR_ACCUM_FILE, 5'h03, 1'b1, 9'h000);
    st(8'h81, 1'b0, 1'b0);
    wrc(1'b1, 5'h03, 8'h81);
  endtask

  // Skip only on a zero result, next instruction dropped
  task automatic t_skip();
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h07f);
    ex(frab_pkg::OP_STORE_ACCUM_TO_FILE, 5'h04, 1'b0, 9'h000);
    ex(frab_pkg::OP_INCREMENT_SKIP_ZERO, 5'h03, 1'b0, 9'h000);
    st(8'h82, 1'b0, 1'b0);
    ex(frab_pkg::OP_INCREMENT_SKIP_ZERO, 5'h04, 1'b1, 9'h000);
    st(8'h82, 1'b0, 1'b1);
    wrc(1'b1, 5'h04, 8'h00);
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h001);
    st(8'h82, 1'b0, 1'b0);
    wrc(1'b0, 5'h00, 8'h00);
  endtask

  // Branch targets with page bits, flush of the next instruction
  task automatic t_branch();
    ex(frab_pkg::OP_MOVE_FILE, 5'h04, 1'b1, 9'h000);
    page_sel_i = 2'b10;
    ex(frab_pkg::OP_UNCONDITIONAL_BRANCH, 5'h00, 1'b0, 9'h1ff);
    pc_e = 11'h5ff;
    st(8'h82, 1'b1, 1'b1);
    ex(frab_pkg::OP_INCREMENT_FILE, 5'h04, 1'b0, 9'h000);
    st(8'h82, 1'b1, 1'b0);
    page_sel_i = 2'b01;
    ex(frab_pkg::OP_UNCONDITIONAL_BRANCH, 5'h00, 1'b0, 9'h000);
    pc_e = 11'h200;
    u_dec.idle();
    st(8'h82, 1'b1, 1'b1);
    ex(frab_pkg::OP_MOVE_FILE, 5'h04, 1'b0, 9'h000);
    st(8'h82, 1'b1, 1'b0);
  endtask

  // Clock enable low freezes everything
  task automatic t_ce();
    ce_i = 1'b0;
    u_dec.issue(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h07f);
    st(8'h82, 1'b1, 1'b0);
    ce_i = 1'b1;
    ex(frab_pkg::OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h001);
    st(8'h83, 1'b0, 1'b0);
    ex(frab_pkg::OP_NOP, 5'h03, 1'b1, 9'h1ff);
    st(8'h83, 1'b0, 1'b0);
    wrc(1'b0, 5'h00, 8'h00);
    u_dec.idle();
  endtask

  // Mid-run reset clears state and file registers
  task automatic t_reset();
    rst_i = 1'b1;
    u_dec.idle();
    u_dec.idle();
    rst_i = 1'b0;
    pc_e = 11'h000;
    st(8'h00, 1'b0, 1'b0);
    wrc(1'b0, 5'h00, 8'h00);
    peek(5'h03, 8'h00);
    ex(frab_pkg::OP_INCREMENT_FILE, 5'h03, 1'b0, 9'h000);
    st(8'h01, 1'b0, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    st(8'h00, 1'b0, 1'b0);
    t_or_lit();
    t_move_store();
    t_increment_file();
    t_orwf();
    t_skip();
    t_branch();
    t_ce();
    t_reset();
    end_sim();
  end
endmodule // tb_file_reg_alu_branch_subset
